/* src/touch_probe_position_latch.sv */
// Purpose: Two touch probe channels latching feedback position on trigger edges
// Assumes: Object access port on clk_sys; probe pins and index are asynchronous
// Notes:   Position input is on clk_sys and sampled with no extra delay
//
// Functional notes
// - Two independent latch channels, armed and running concurrently.
// - Channel one uses function low byte, reports in status low byte.
// - Channel two uses function high byte, reports in status high byte.
// - Channel one captures land only in channel one position registers.
// - Channel two captures land only in channel two position registers.
// - Function bit 2 picks probe input one or encoder index.
// - Function bit 10 picks probe input two or encoder index.
// - Function bit 0 enables channel one; disabled channel captures nothing.
// - Mode bit zero: capture only the first qualifying rise and the first qualifying fall after arming.
// - Mode bit one: capture every qualifying event, overwriting the old value.
// - Function bit 4 enables channel one rising edge capture.
// - Function bit 5 enables channel one falling edge capture.
// - Function bit 12 enables channel two rising edge capture.
// - Function bit 13 enables channel two falling edge capture.
// - Channel one rise and fall captures go to separate signed registers.
// - Channel two rise and fall captures go to separate signed registers.
// - Function word is 16-bit read-write, resets zero, reserved bits zero.
// - Status bits 1,2 and 9,10 flag stored rise and fall positions.
// - Status bits 6,7 and 14,15 count continuous executions modulo four.
// - Status bits 0 and 8 show each channel enabled.

`timescale 1ns/100ps

module touch_probe_position_latch
    import probe_latch_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic probe_one_pin,
    input wire logic probe_two_pin,
    input wire logic encoder_index,
    input wire logic signed [probe_latch_pkg::POS_WIDTH-1:0] feedback_position,
    input wire logic [probe_latch_pkg::INDEX_WIDTH-1:0] od_index,
    input wire logic od_wr,
    input wire logic od_rd,
    input wire logic [probe_latch_pkg::DATA_WIDTH-1:0] od_wdata,
    output logic [probe_latch_pkg::DATA_WIDTH-1:0] od_rdata,
    output logic od_ack,
    output logic od_err
);

    import probe_latch_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [1:0] count_step(input logic [1:0] cnt);
        count_step = cnt + 2'h1;
    endfunction : count_step

    function automatic logic [7:0] fn_byte(input logic [15:0] word, input int ch);
        fn_byte = word[ch*CHANNEL_SHIFT +: 8];
    endfunction : fn_byte

    // ------------------------------------------------------------
    // Trigger synchronisers
    // ------------------------------------------------------------
    logic pin_one_rise;
    logic pin_one_fall;
    logic pin_two_rise;
    logic pin_two_fall;
    logic index_rise;
    logic index_fall;

    // Edge detection runs on synchronised levels only
    edge_sync u_sync_one (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(probe_one_pin),
        .level(),
        .rise(pin_one_rise),
        .fall(pin_one_fall)
    );

    edge_sync u_sync_two (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(probe_two_pin),
        .level(),
        .rise(pin_two_rise),
        .fall(pin_two_fall)
    );

    edge_sync u_sync_index (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in(encoder_index),
        .level(),
        .rise(index_rise),
        .fall(index_fall)
    );

    // ------------------------------------------------------------
    // Object access decode
    // ------------------------------------------------------------
    logic [15:0] function_word;
    logic [15:0] status_word;
    logic [POS_WIDTH-1:0] position [4];
    logic sel_function;
    logic sel_status;
    logic sel_pos_one_rise;
    logic sel_pos_one_fall;
    logic sel_pos_two_rise;
    logic sel_pos_two_fall;
    logic sel_any;
    logic access;
    logic bad_access;
    logic function_write;
    logic [DATA_WIDTH-1:0] next_rdata;

    assign sel_function = (od_index == IDX_FUNCTION);
    assign sel_status = (od_index == IDX_STATUS);
    assign sel_pos_one_rise = (od_index == IDX_ONE_RISE);
    assign sel_pos_one_fall = (od_index == IDX_ONE_FALL);
    assign sel_pos_two_rise = (od_index == IDX_TWO_RISE);
    assign sel_pos_two_fall = (od_index == IDX_TWO_FALL);
    assign sel_any = sel_function | sel_status | sel_pos_one_rise | sel_pos_one_fall
                   | sel_pos_two_rise | sel_pos_two_fall;
    assign access = od_wr | od_rd;
    // Writes to read-only objects are refused, nothing changes
    assign bad_access = access & (~sel_any | (od_wr & ~sel_function));
    assign function_write = od_wr & sel_function;

    // Else-if chain expressed as a priority select
    assign next_rdata = sel_function ? {16'h0000, function_word} :
                        sel_status ? {16'h0000, status_word} :
                        sel_pos_one_rise ? position[0] :
                        sel_pos_one_fall ? position[1] :
                        sel_pos_two_rise ? position[2] :
                        sel_pos_two_fall ? position[3] :
                        32'h0000_0000;

    // ------------------------------------------------------------
    // Function word
    // ------------------------------------------------------------
    // Reserved bits are forced low so they always read back zero
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            function_word <= FUNCTION_RESET;
        end else if (function_write) begin
            function_word <= od_wdata[15:0] & FUNCTION_WRITABLE;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            od_rdata <= 32'h0000_0000;
            od_ack <= 1'b0;
            od_err <= 1'b0;
        end else begin
            od_ack <= access;
            od_err <= bad_access;
            if (od_rd & ~bad_access) begin
                od_rdata <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------
    logic [1:0] ch_enable;
    logic [1:0] ch_mode;
    logic [1:0] ch_source;
    logic [1:0] ch_rise_en;
    logic [1:0] ch_fall_en;
    logic [1:0] ch_pin_rise;
    logic [1:0] ch_pin_fall;
    logic [1:0] trig_rise;
    logic [1:0] trig_fall;
    logic [1:0] rise_cap;
    logic [1:0] fall_cap;
    logic [1:0] rearm;
    logic [1:0] enable_prev;
    logic [1:0] rise_stored;
    logic [1:0] fall_stored;
    logic [1:0] exec_count [2];

    assign ch_pin_rise = {pin_two_rise, pin_one_rise};
    assign ch_pin_fall = {pin_two_fall, pin_one_fall};

    for (genvar c = 0; c < 2; c++) begin : g_channel
        logic [7:0] cfg;
        logic any_cap;

        // Each channel reads only its own byte
        assign cfg = fn_byte(function_word, c);
        assign ch_enable[c] = cfg[FN_ENABLE];
        assign ch_mode[c] = cfg[FN_MODE];
        assign ch_source[c] = cfg[FN_SOURCE];
        assign ch_rise_en[c] = cfg[FN_RISE_EN];
        assign ch_fall_en[c] = cfg[FN_FALL_EN];

        // Source select: own pin or shared encoder index
        assign trig_rise[c] = ch_source[c] ? index_rise : ch_pin_rise[c];
        assign trig_fall[c] = ch_source[c] ? index_fall : ch_pin_fall[c];

        // Single mode latches once per edge kind until re-armed
        assign rise_cap[c] = ch_enable[c] & ch_rise_en[c] & trig_rise[c]
                           & (ch_mode[c] | ~rise_stored[c]);
        assign fall_cap[c] = ch_enable[c] & ch_fall_en[c] & trig_fall[c]
                           & (ch_mode[c] | ~fall_stored[c]);
        assign any_cap = rise_cap[c] | fall_cap[c];
        assign rearm[c] = ch_enable[c] & ~enable_prev[c];

        // A capture in the re-arm cycle wins over the clear
        always_ff @(posedge clk_sys) begin
            if (rst) begin
                enable_prev[c] <= 1'b0;
                rise_stored[c] <= 1'b0;
                fall_stored[c] <= 1'b0;
                exec_count[c] <= 2'h0;
            end else begin
                enable_prev[c] <= ch_enable[c];
                if (rise_cap[c]) begin
                    rise_stored[c] <= 1'b1;
                end else if (rearm[c]) begin
                    rise_stored[c] <= 1'b0;
                end
                if (fall_cap[c]) begin
                    fall_stored[c] <= 1'b1;
                end else if (rearm[c]) begin
                    fall_stored[c] <= 1'b0;
                end
                if (any_cap & ch_mode[c]) begin
                    exec_count[c] <= count_step(exec_count[c]);
                end else if (rearm[c]) begin
                    exec_count[c] <= 2'h0;
                end
            end
        end

        // Rise and fall held apart, each in its own channel pair
        capture_register #(
            .WIDTH(POS_WIDTH)
        ) u_rise_pos (
            .clk_sys(clk_sys),
            .rst(rst),
            .load(rise_cap[c]),
            .data_in(feedback_position),
            .value(position[2*c])
        );

        capture_register #(
            .WIDTH(POS_WIDTH)
        ) u_fall_pos (
            .clk_sys(clk_sys),
            .rst(rst),
            .load(fall_cap[c]),
            .data_in(feedback_position),
            .value(position[2*c+1])
        );

        // Status byte for this channel
        assign status_word[c*CHANNEL_SHIFT +: 8] = {exec_count[c], 3'b000, fall_stored[c],
                                                    rise_stored[c], ch_enable[c]};

        // ------------------------------------------------------------
        // Checks
        // ------------------------------------------------------------
        a_rise_pos_value: assert property (
            @(posedge clk_sys) disable iff (rst)
            rise_cap[c] |=> position[2*c] == $past(feedback_position))
        else $error("Rise position not latched from feedback");

        a_fall_pos_value: assert property (
            @(posedge clk_sys) disable iff (rst)
            fall_cap[c] |=> position[2*c+1] == $past(feedback_position))
        else $error("Fall position not latched from feedback");

        a_pos_hold: assert property (
            @(posedge clk_sys) disable iff (rst)
            !rise_cap[c] |=> $stable(position[2*c]))
        else $error("Rise position changed without a capture");

        a_disabled_quiet: assert property (
            @(posedge clk_sys) disable iff (rst)
            !ch_enable[c] |-> !rise_cap[c] && !fall_cap[c])
        else $error("Disabled channel captured");

        a_single_once: assert property (
            @(posedge clk_sys) disable iff (rst)
            !ch_mode[c] && rise_stored[c] |-> !rise_cap[c])
        else $error("Single mode captured twice");

        a_cont_every: assert property (
            @(posedge clk_sys) disable iff (rst)
            ch_mode[c] && ch_enable[c] && ch_rise_en[c] && trig_rise[c] |-> rise_cap[c])
        else $error("Continuous mode missed an edge");

        a_edge_gates: assert property (
            @(posedge clk_sys) disable iff (rst)
            (rise_cap[c] |-> ch_rise_en[c]) and (fall_cap[c] |-> ch_fall_en[c]))
        else $error("Capture on a disabled edge");

        a_count_wrap: assert property (
            @(posedge clk_sys) disable iff (rst)
            ch_mode[c] && any_cap |=> exec_count[c] == 2'($past(exec_count[c]) + 2'h1))
        else $error("Execution count did not advance");

        a_stored_flag: assert property (
            @(posedge clk_sys) disable iff (rst)
            fall_cap[c] |=> status_word[c*CHANNEL_SHIFT+ST_FALL])
        else $error("Fall stored flag not set");

        a_rearm_clear: assert property (
            @(posedge clk_sys) disable iff (rst)
            rearm[c] && !rise_cap[c] |=> !rise_stored[c])
        else $error("Re-arm did not clear rise flag");

        a_enable_status: assert property (
            @(posedge clk_sys) disable iff (rst)
            status_word[c*CHANNEL_SHIFT+ST_ENABLED] == function_word[c*CHANNEL_SHIFT+FN_ENABLE])
        else $error("Enabled status does not follow function bit");
    end

    // ------------------------------------------------------------
    // Access checks
    // ------------------------------------------------------------
    a_function_mask: assert property (
        @(posedge clk_sys) disable iff (rst)
        (function_word & ~FUNCTION_WRITABLE) == 16'h0000)
    else $error("Reserved function bits set");

    a_function_write: assert property (
        @(posedge clk_sys) disable iff (rst)
        function_write |=> function_word == ($past(od_wdata[15:0]) & FUNCTION_WRITABLE))
    else $error("Function write not stored");

    a_status_reserved: assert property (
        @(posedge clk_sys) disable iff (rst)
        (status_word & 16'h3838) == 16'h0000)
    else $error("Reserved status bits set");

    a_ack_timing: assert property (
        @(posedge clk_sys) disable iff (rst)
        access |=> od_ack ##1 !od_ack || $past(access))
    else $error("Access not answered next cycle");

endmodule : touch_probe_position_latch

/* common/probe_latch_pkg.sv */
// Purpose: Shared constants for the two-channel touch probe position latch
// Assumes: Object dictionary indices are used directly as register addresses
// Notes:   Each channel owns one byte of the function and status words

package probe_latch_pkg;

    // ------------------------------------------------------------
    // Object indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_FUNCTION = 16'h60b8;
    localparam logic [15:0] IDX_STATUS = 16'h60b9;
    localparam logic [15:0] IDX_ONE_RISE = 16'h60ba;
    localparam logic [15:0] IDX_ONE_FALL = 16'h60bb;
    localparam logic [15:0] IDX_TWO_RISE = 16'h60bc;
    localparam logic [15:0] IDX_TWO_FALL = 16'h60bd;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int INDEX_WIDTH = 16;
    localparam int WORD_WIDTH = 16;
    localparam int DATA_WIDTH = 32;
    localparam int POS_WIDTH = 32;
    localparam int CHANNEL_SHIFT = 8;
    localparam logic [15:0] FUNCTION_RESET = 16'h0000;
    localparam logic [15:0] FUNCTION_WRITABLE = 16'h3737;
    localparam logic [31:0] POSITION_RESET = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions inside one channel byte
    // ------------------------------------------------------------
    localparam int FN_ENABLE = 0;
    localparam int FN_MODE = 1;
    localparam int FN_SOURCE = 2;
    localparam int FN_RISE_EN = 4;
    localparam int FN_FALL_EN = 5;
    localparam int ST_ENABLED = 0;
    localparam int ST_RISE = 1;
    localparam int ST_FALL = 2;
    localparam int ST_COUNT = 6;

endpackage : probe_latch_pkg

/* src/edge_sync.sv */
// Purpose: Two-flop synchroniser with rise and fall pulses
// Assumes: Input is asynchronous to clk_sys
// Notes:   Edges are taken between the second and third flop only

`timescale 1ns/100ps

module edge_sync (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic async_in,
    output logic level,
    output logic rise,
    output logic fall
);

    logic meta;
    logic stable;
    logic prev;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            meta <= 1'b0;
            stable <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= async_in;
            stable <= meta;
            prev <= stable;
        end
    end

    assign level = stable;
    assign rise = stable & ~prev;
    assign fall = ~stable & prev;

endmodule : edge_sync

/* src/capture_register.sv */
// Purpose: Read-only position holding register loaded by a strobe
// Assumes: Load strobe and data on clk_sys
// Notes:   Holds its value until the next load

`timescale 1ns/100ps

module capture_register #(
    parameter int WIDTH = 32
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [WIDTH-1:0] data_in,
    output logic [WIDTH-1:0] value
);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            value <= '0;
        end else if (load) begin
            value <= data_in;
        end
    end

endmodule : capture_register

/* bench/od_host.sv */
// Purpose: Host side of the object port, issuing single object accesses
// Assumes: Requests launched just after a clk_sys edge, one-cycle strobes
// Notes:   Released lines show inverted values so stale data is never mistaken

`timescale 1ns/100ps

module od_host (
    input wire logic clk_sys,
    input wire logic [31:0] od_rdata,
    input wire logic od_ack,
    input wire logic od_err,
    output logic [15:0] od_index,
    output logic od_wr,
    output logic od_rd,
    output logic [31:0] od_wdata
);
    initial begin
        od_index = 16'h0000;
        od_wr = 1'b0;
        od_rd = 1'b0;
        od_wdata = 32'h0000_0000;
    end

    // Reserved function bits are left for the caller to send as zero
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] data,
                          output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        @(posedge clk_sys);
        od_index <= idx;
        od_wdata <= data;
        od_wr <= wr;
        od_rd <= !wr;
        // Strobes are one-cycle pulses; the port takes them at this edge
        @(posedge clk_sys);
        od_wr <= 1'b0;
        od_rd <= 1'b0;
        od_index <= ~idx;
        od_wdata <= ~data;
        // Answer is taken at the edge that samples od_ack high
        do begin
            @(posedge clk_sys);
            n++;
        end while (od_ack !== 1'b1 && n < 4);
        rdata = od_rdata;
        err = (od_ack === 1'b1) ? od_err : 1'bx;
    endtask : access
endmodule : od_host

/* bench/touch_probe_position_latch_tb.sv */
// Purpose: Self-checking bench for the two-channel probe latch
// Assumes: Pins held at least 6 cycles per level, well beyond synchroniser latency
// Notes:   Position is held steady across each edge so the capture is known

`timescale 1ns/100ps

module touch_probe_position_latch_tb;
    import probe_latch_pkg::*;

    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic probe_one_pin = 1'b0;
    logic probe_two_pin = 1'b0;
    logic encoder_index = 1'b0;
    logic signed [POS_WIDTH-1:0] feedback_position = 32'sh0;
    logic [15:0] od_index;
    logic od_wr;
    logic od_rd;
    logic [31:0] od_wdata;
    logic [31:0] od_rdata;
    logic od_ack;
    logic od_err;
    int num_errors = 0;
    int checks = 0;

    always #2 clk_sys = ~clk_sys;

    touch_probe_position_latch touch_probe_position_latch_i (.clk_sys(clk_sys), .rst(rst),
        .probe_one_pin(probe_one_pin), .probe_two_pin(probe_two_pin), .encoder_index(encoder_index),
        .feedback_position(feedback_position), .od_index(od_index), .od_wr(od_wr), .od_rd(od_rd),
        .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err));

    od_host od_host_i (.clk_sys(clk_sys), .od_rdata(od_rdata), .od_ack(od_ack), .od_err(od_err),
        .od_index(od_index), .od_wr(od_wr), .od_rd(od_rd), .od_wdata(od_wdata));

    // ------------------------------------------------------------
    // Compare and access tasks
    // ------------------------------------------------------------
    task automatic check_value(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: data %h expected %h", $time, got, exp);
        end
    endtask : check_value

    task automatic check_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: error flag %b expected %b", $time, got, exp);
        end
    endtask : check_flag

    task automatic rd(input logic [15:0] idx, input logic [31:0] exp, input logic exp_err);
        logic [31:0] d;
        logic e;
        od_host_i.access(1'b0, idx, 32'h0000_0000, d, e);
        check_flag(e, exp_err);
        if (!exp_err) begin
            check_value(d, exp);
        end
    endtask : rd

    task automatic wr(input logic [15:0] idx, input logic [31:0] data, input logic exp_err);
        logic [31:0] d;
        logic e;
        od_host_i.access(1'b1, idx, data, d, e);
        check_flag(e, exp_err);
    endtask : wr

    // Which: 0 probe one pin, 1 probe two pin, 2 encoder index
    task automatic pulse(input int which, input logic signed [31:0] pr, input logic signed [31:0] pf);
        @(posedge clk_sys);
        feedback_position <= pr;
        repeat (2) @(posedge clk_sys);
        if (which == 0) probe_one_pin <= 1'b1;
        else if (which == 1) probe_two_pin <= 1'b1;
        else encoder_index <= 1'b1;
        repeat (6) @(posedge clk_sys);
        feedback_position <= pf;
        repeat (2) @(posedge clk_sys);
        probe_one_pin <= 1'b0;
        probe_two_pin <= 1'b0;
        encoder_index <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : pulse

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            rd(IDX_FUNCTION + 16'(i), 32'h0000_0000, 1'b0);
        end
        rd(16'h60be, 32'h0000_0000, 1'b1);
        wr(IDX_ONE_RISE, 32'h0000_1234, 1'b1);
        rd(IDX_ONE_RISE, 32'h0000_0000, 1'b0);
        $display("test reset and access done");

        wr(IDX_FUNCTION, 32'h0000_3737, 1'b0);
        rd(IDX_FUNCTION, 32'h0000_3737, 1'b0);
        rd(IDX_STATUS, 32'h0000_0101, 1'b0);
        $display("test function word done");

        wr(IDX_FUNCTION, 32'h0000_0000, 1'b0);
        wr(IDX_FUNCTION, 32'h0000_0031, 1'b0);
        pulse(0, 32'sd100, -32'sd200);
        rd(IDX_ONE_RISE, 32'h0000_0064, 1'b0);
        rd(IDX_ONE_FALL, 32'hffff_ff38, 1'b0);
        rd(IDX_STATUS, 32'h0000_0007, 1'b0);
        pulse(0, 32'sd300, 32'sd400);
        rd(IDX_ONE_RISE, 32'h0000_0064, 1'b0);
        rd(IDX_ONE_FALL, 32'hffff_ff38, 1'b0);
        rd(IDX_TWO_RISE, 32'h0000_0000, 1'b0);
        $display("test single capture done");

        wr(IDX_FUNCTION, 32'h0000_0000, 1'b0);
        pulse(0, 32'sd50, 32'sd51);
        rd(IDX_ONE_RISE, 32'h0000_0064, 1'b0);
        wr(IDX_FUNCTION, 32'h0000_0031, 1'b0);
        rd(IDX_STATUS, 32'h0000_0001, 1'b0);
        wr(IDX_FUNCTION, 32'h0000_0021, 1'b0);
        pulse(0, 32'sd60, 32'sd70);
        rd(IDX_ONE_RISE, 32'h0000_0064, 1'b0);
        rd(IDX_ONE_FALL, 32'h0000_0046, 1'b0);
        rd(IDX_STATUS, 32'h0000_0005, 1'b0);
        $display("test re-arm done");

        wr(IDX_FUNCTION, 32'h0000_1700, 1'b0);
        for (int i = 0; i < 5; i++) begin
            pulse(2, 32'sd1000 + i, 32'sd900);
        end
        rd(IDX_TWO_RISE, 32'h0000_03ec, 1'b0);
        rd(IDX_TWO_FALL, 32'h0000_0000, 1'b0);
        rd(IDX_STATUS, 32'h0000_4304, 1'b0);
        rd(IDX_ONE_FALL, 32'h0000_0046, 1'b0);
        $display("test continuous index done");

        wr(IDX_FUNCTION, 32'h0000_1717, 1'b0);
        pulse(2, 32'sd2000, 32'sd1900);
        pulse(0, 32'sd2100, 32'sd2200);
        rd(IDX_ONE_RISE, 32'h0000_07d0, 1'b0);
        rd(IDX_TWO_RISE, 32'h0000_07d0, 1'b0);
        rd(IDX_STATUS, 32'h0000_8343, 1'b0);
        rd(IDX_ONE_FALL, 32'h0000_0046, 1'b0);
        rd(IDX_TWO_FALL, 32'h0000_0000, 1'b0);
        $display("test shared index done");

        wr(IDX_FUNCTION, 32'h0000_3300, 1'b0);
        pulse(1, 32'sd3000, 32'sd3100);
        rd(IDX_TWO_RISE, 32'h0000_0bb8, 1'b0);
        rd(IDX_TWO_FALL, 32'h0000_0c1c, 1'b0);
        rd(IDX_STATUS, 32'h0000_0742, 1'b0);
        $display("test probe two pin done");

        // Reset in mid-run must clear function word, flags, counts and positions
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(IDX_FUNCTION, 32'h0000_0000, 1'b0);
        rd(IDX_STATUS, 32'h0000_0000, 1'b0);
        rd(IDX_TWO_FALL, 32'h0000_0000, 1'b0);
        $display("test mid-run reset done");
        end_of_test();
    end

    // Tests take well under a thousand cycles; fifty thousand marks a hang
    initial begin
        #200000;
        num_errors++;
        $display("wrong value at %0t: run did not finish", $time);
        end_of_test();
    end
endmodule : touch_probe_position_latch_tb
